// *** hdl/pss_defs.svh ***
// field positions, reset values and source codes of the pulse source selector
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// ****************************************************************
// register width and phase count
// ****************************************************************
`define PSS_REG_W        9
`define PSS_NUM_PHASE    3

// ****************************************************************
// source select fields
// ****************************************************************
`define PSS_SEL2_LSB     3
`define PSS_SEL2_MSB     5
`define PSS_SEL3_LSB     6
`define PSS_SEL3_MSB     8
`define PSS_SEL2_RST     3'h1
`define PSS_SEL3_RST     3'h2

// ****************************************************************
// phase inclusion fields of the computation mode register
// ****************************************************************
`define PSS_INC2_LSB     3
`define PSS_INC2_MSB     5
`define PSS_INC3_LSB     6
`define PSS_INC3_MSB     8
`define PSS_INC_RST      3'h7

// ****************************************************************
// source codes
// ****************************************************************
`define PSS_SRC_TOT_ACT  3'h0
`define PSS_SRC_TOT_REA  3'h1
`define PSS_SRC_APP      3'h2
`define PSS_SRC_FUN_ACT  3'h3
`define PSS_SRC_FUN_REA  3'h4

`endif

// *** hdl/pss_pkg.sv ***
// types shared by the pulse source selector
package pss_pkg;
  typedef logic [2:0] pss_src_t;
  typedef logic [2:0] pss_phase_t;
endpackage : pss_pkg

// *** hdl/pss_src_mux.sv ***
// one pulse output: source decode and sum over included phases
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_src_mux #(
  parameter int PW = 24,
  parameter int SW = PW + 2
) (
  // source quantities, phase 0 in the low slice
  input  wire logic [3*PW-1:0]       tot_act,
  input  wire logic [3*PW-1:0]       tot_rea,
  input  wire logic [3*PW-1:0]       app,
  input  wire logic [3*PW-1:0]       fun_act,
  input  wire logic [3*PW-1:0]       fun_rea,
  // configuration
  input  wire pss_pkg::pss_src_t     sel,
  input  wire pss_pkg::pss_phase_t   incl,
  // result
  output logic signed [SW-1:0]       sum,
  output logic                       gen
);

  logic [3*PW-1:0] src;
  logic signed [SW-1:0] acc;
  logic [PW-1:0] slice;

  // ****************************************************************
  // source decode
  // ****************************************************************
  always_comb begin
    src = '0;
    gen = 1'b1;
    case (sel)
      `PSS_SRC_TOT_ACT: src = tot_act;
      `PSS_SRC_TOT_REA: src = tot_rea;
      `PSS_SRC_APP:     src = app;
      `PSS_SRC_FUN_ACT: src = fun_act;
      `PSS_SRC_FUN_REA: src = fun_rea;
      // reserved codes stop the output entirely
      default:          gen = 1'b0;
    endcase
  end

  // ****************************************************************
  // phase sum
  // ****************************************************************
  always_comb begin
    acc = '0;
    slice = '0;
    for (int i = 0; i < `PSS_NUM_PHASE; i++) begin
      slice = src[i*PW +: PW];
      if (incl[i]) begin
        acc = acc + signed'({{(SW-PW){slice[PW-1]}}, slice});
      end
    end
    sum = gen ? acc : '0;
  end

endmodule : pss_src_mux

// *** hdl/pss_top.sv ***
// selects the quantity behind the second and third pulse outputs
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_top #(
  parameter int PW = 24,
  parameter int SW = PW + 2
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // source select register write and readback
  input  wire logic                 cfg_wr,
  input  wire logic [8:0]           cfg_wdata,
  output logic [8:0]                cfg_rdata,
  // computation mode register write and readback
  input  wire logic                 mode_wr,
  input  wire logic [8:0]           mode_wdata,
  output logic [8:0]                mode_rdata,
  // per phase power samples, phase 0 in the low slice
  input  wire logic                 pwr_valid,
  input  wire logic [3*PW-1:0]      tot_act,
  input  wire logic [3*PW-1:0]      tot_rea,
  input  wire logic [3*PW-1:0]      app,
  input  wire logic [3*PW-1:0]      fun_act,
  input  wire logic [3*PW-1:0]      fun_rea,
  // to the pulse converters
  output logic                      sum_valid,
  output logic signed [SW-1:0]      second_pulse_output_power,
  output logic                      second_pulse_output_en,
  output logic signed [SW-1:0]      third_pulse_output_power,
  output logic                      third_pulse_output_en
);

  // ****************************************************************
  // configuration state
  // ****************************************************************
  pss_pkg::pss_src_t   second_pulse_source_select_q;
  pss_pkg::pss_src_t   second_pulse_source_select_d;
  pss_pkg::pss_src_t   third_pulse_source_select_q;
  pss_pkg::pss_src_t   third_pulse_source_select_d;
  pss_pkg::pss_phase_t second_pulse_phase_include_q;
  pss_pkg::pss_phase_t second_pulse_phase_include_d;
  pss_pkg::pss_phase_t third_pulse_phase_include_q;
  pss_pkg::pss_phase_t third_pulse_phase_include_d;
  logic [8:0]          cfg_rdata_q;
  logic [8:0]          cfg_rdata_d;
  logic [8:0]          mode_rdata_q;
  logic [8:0]          mode_rdata_d;

  // ****************************************************************
  // output state
  // ****************************************************************
  logic                sum_valid_q;
  logic                sum_valid_d;
  logic signed [SW-1:0] p2_q;
  logic signed [SW-1:0] p2_d;
  logic signed [SW-1:0] p3_q;
  logic signed [SW-1:0] p3_d;
  logic                en2_q;
  logic                en2_d;
  logic                en3_q;
  logic                en3_d;

  logic signed [SW-1:0] p2_sum;
  logic signed [SW-1:0] p3_sum;
  logic                 p2_gen;
  logic                 p3_gen;

  // ****************************************************************
  // configuration next state
  // ****************************************************************
  always_comb begin
    second_pulse_source_select_d = second_pulse_source_select_q;
    third_pulse_source_select_d  = third_pulse_source_select_q;
    second_pulse_phase_include_d = second_pulse_phase_include_q;
    third_pulse_phase_include_d  = third_pulse_phase_include_q;
    if (cfg_wr) begin
      second_pulse_source_select_d =
        cfg_wdata[`PSS_SEL2_MSB:`PSS_SEL2_LSB];
      third_pulse_source_select_d =
        cfg_wdata[`PSS_SEL3_MSB:`PSS_SEL3_LSB];
    end
    if (mode_wr) begin
      second_pulse_phase_include_d =
        mode_wdata[`PSS_INC2_MSB:`PSS_INC2_LSB];
      third_pulse_phase_include_d =
        mode_wdata[`PSS_INC3_MSB:`PSS_INC3_LSB];
    end
    // bits 2:0 belong to the first output, not kept here
    cfg_rdata_d = '0;
    cfg_rdata_d[`PSS_SEL2_MSB:`PSS_SEL2_LSB] = second_pulse_source_select_d;
    cfg_rdata_d[`PSS_SEL3_MSB:`PSS_SEL3_LSB] = third_pulse_source_select_d;
    mode_rdata_d = '0;
    mode_rdata_d[`PSS_INC2_MSB:`PSS_INC2_LSB] = second_pulse_phase_include_d;
    mode_rdata_d[`PSS_INC3_MSB:`PSS_INC3_LSB] = third_pulse_phase_include_d;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // second select resets to total reactive
      second_pulse_source_select_q <= `PSS_SEL2_RST;
      third_pulse_source_select_q  <= `PSS_SEL3_RST;
      second_pulse_phase_include_q <= `PSS_INC_RST;
      third_pulse_phase_include_q  <= `PSS_INC_RST;
      cfg_rdata_q                  <= '0;
      mode_rdata_q                 <= '0;
    end else begin
      second_pulse_source_select_q <= second_pulse_source_select_d;
      third_pulse_source_select_q  <= third_pulse_source_select_d;
      second_pulse_phase_include_q <= second_pulse_phase_include_d;
      third_pulse_phase_include_q  <= third_pulse_phase_include_d;
      cfg_rdata_q                  <= cfg_rdata_d;
      mode_rdata_q                 <= mode_rdata_d;
    end
  end

  // ****************************************************************
  // source selection per output
  // ****************************************************************
  // second output decode and reserved stop
  pss_src_mux #(
    .PW (PW),
    .SW (SW)
  ) u_second (
    .tot_act (tot_act),
    .tot_rea (tot_rea),
    .app     (app),
    .fun_act (fun_act),
    .fun_rea (fun_rea),
    .sel     (second_pulse_source_select_q),
    .incl    (second_pulse_phase_include_q),
    .sum     (p2_sum),
    .gen     (p2_gen)
  );

  // third output decode and reserved stop
  pss_src_mux #(
    .PW (PW),
    .SW (SW)
  ) u_third (
    .tot_act (tot_act),
    .tot_rea (tot_rea),
    .app     (app),
    .fun_act (fun_act),
    .fun_rea (fun_rea),
    .sel     (third_pulse_source_select_q),
    .incl    (third_pulse_phase_include_q),
    .sum     (p3_sum),
    .gen     (p3_gen)
  );

  // ****************************************************************
  // output next state
  // ****************************************************************
  // sums follow the sample strobe; enables track config at once so a
  // reserved code silences the converter without waiting for a sample
  always_comb begin
    sum_valid_d = pwr_valid;
    p2_d        = p2_q;
    p3_d        = p3_q;
    en2_d       = p2_gen;
    en3_d       = p3_gen;
    if (pwr_valid) begin
      p2_d = p2_sum;
      p3_d = p3_sum;
    end
    if (!p2_gen) begin
      p2_d = '0;
    end
    if (!p3_gen) begin
      p3_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sum_valid_q <= 1'b0;
      p2_q        <= '0;
      p3_q        <= '0;
      en2_q       <= 1'b0;
      en3_q       <= 1'b0;
    end else begin
      sum_valid_q <= sum_valid_d;
      p2_q        <= p2_d;
      p3_q        <= p3_d;
      en2_q       <= en2_d;
      en3_q       <= en3_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cfg_rdata                 = cfg_rdata_q;
  assign mode_rdata                = mode_rdata_q;
  assign sum_valid                 = sum_valid_q;
  assign second_pulse_output_power = p2_q;
  assign second_pulse_output_en    = en2_q;
  assign third_pulse_output_power  = p3_q;
  assign third_pulse_output_en     = en3_q;

endmodule : pss_top

// *** tb/pss_top_assertions.sv ***
// port checker of the pulse source selector
`timescale 1ns/1ps
module pss_top_assertions #(
  parameter int PW = 24,
  parameter int SW = PW + 2
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rstn,
  // configuration
  input wire logic                 cfg_wr,
  input wire logic [8:0]           cfg_wdata,
  input wire logic [8:0]           cfg_rdata,
  input wire logic                 mode_wr,
  input wire logic [8:0]           mode_wdata,
  input wire logic [8:0]           mode_rdata,
  // samples and results
  input wire logic                 pwr_valid,
  input wire logic                 sum_valid,
  input wire logic signed [SW-1:0] second_pulse_output_power,
  input wire logic                 second_pulse_output_en,
  input wire logic signed [SW-1:0] third_pulse_output_power,
  input wire logic                 third_pulse_output_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_sel_rdback: assert property (
    cfg_wr |=> cfg_rdata == {$past(cfg_wdata[8:3]), 3'h0})
    else $error("select readback wrong");
  chk_mode_rdback: assert property (
    mode_wr |=> mode_rdata == {$past(mode_wdata[8:3]), 3'h0})
    else $error("mode readback wrong");
  // en lags reset release by one edge
  // en is decoded from the select register, one edge behind its readback
  chk_en2_code: assert property (
    $past(rstn) && $past(rstn, 2) |->
      second_pulse_output_en == ($past(cfg_rdata[5:3]) < 3'h5))
    else $error("second enable disagrees with select");
  chk_en3_code: assert property (
    $past(rstn) && $past(rstn, 2) |->
      third_pulse_output_en == ($past(cfg_rdata[8:6]) < 3'h5))
    else $error("third enable disagrees with select");
  chk_valid_lat: assert property (
    pwr_valid |=> sum_valid)
    else $error("sum valid missing");
  chk_valid_once: assert property (
    !pwr_valid |=> !sum_valid)
    else $error("sum valid without sample");
  chk_pow2_zero: assert property (
    pwr_valid && cfg_rdata[5:3] > 3'h4 |=> second_pulse_output_power == '0)
    else $error("second power on reserved code");
  chk_pow3_zero: assert property (
    pwr_valid && cfg_rdata[8:6] > 3'h4 |=> third_pulse_output_power == '0)
    else $error("third power on reserved code");
  // a select write one edge earlier may still zero the sums
  chk_pow_hold: assert property (
    !pwr_valid && !cfg_wr && !mode_wr && !$past(cfg_wr) |=>
      $stable(second_pulse_output_power) && $stable(third_pulse_output_power))
    else $error("power changed without sample");

  cover property (pwr_valid && cfg_rdata[5:3] == 3'h4);
  cover property (cfg_wr && cfg_wdata[8:6] == 3'h7);
  cover property (mode_wr && mode_wdata[5:3] == 3'h0);
endmodule : pss_top_assertions

// *** tb/pss_top_tb.sv ***
// self-checking bench of the pulse source selector
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module pss_top_tb;
  localparam int PW = 24;
  localparam int SW = 26;
  logic                 mclk, rstn, cfg_wr, mode_wr, pwr_valid;
  logic [8:0]           cfg_wdata, mode_wdata;
  logic [3*PW-1:0]      q [5];
  wire logic [8:0]      cfg_rdata, mode_rdata;
  wire logic            sum_valid, en2, en3;
  wire logic [SW-1:0]   pow2, pow3;
  integer               seed = 32'h3910435d;
  int                   err_count, checked;

  pss_top #(.PW(PW), .SW(SW)) DUT (
    .mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .mode_rdata(mode_rdata), .pwr_valid(pwr_valid), .tot_act(q[0]),
    .tot_rea(q[1]), .app(q[2]), .fun_act(q[3]), .fun_rea(q[4]),
    .sum_valid(sum_valid), .second_pulse_output_power(pow2),
    .second_pulse_output_en(en2), .third_pulse_output_power(pow3),
    .third_pulse_output_en(en3));

  always #20 mclk = ~mclk;

  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic logic [71:0] rnd72();
    logic [95:0] v;
    v = {$random(seed), $random(seed), $random(seed)};
    return v[71:0];
  endfunction : rnd72

  function automatic logic [SW-1:0] expv(input logic [2:0] s,
                                         input logic [2:0] m);
    logic signed [SW-1:0] r;
    r = '0;
    if (s < 3'h5)
      for (int p = 0; p < 3; p++)
        if (m[p]) r += SW'(signed'(q[s][p*PW +: PW]));
    return r;
  endfunction : expv

  task test_done();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task do_reset();
    rstn <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(cfg_rdata, {3'h2, 3'h1, 3'h0})
    `CHK(mode_rdata, 9'h1f8)
    `CHK({en2, en3}, 2'h3)
  endtask : do_reset

  // write both registers, then one sample, then compare
  task run_case(input logic [2:0] s2, s3, m2, m3);
    @(posedge mclk);
    cfg_wr     <= 1'b1;
    cfg_wdata  <= {s3, s2, 3'($random(seed))};
    mode_wr    <= 1'b1;
    mode_wdata <= {m3, m2, 3'($random(seed))};
    @(posedge mclk);
    cfg_wr    <= 1'b0;
    mode_wr   <= 1'b0;
    pwr_valid <= 1'b1;
    for (int k = 0; k < 5; k++) q[k] <= rnd72();
    @(posedge mclk);
    pwr_valid <= 1'b0;
    #1;
    `CHK(sum_valid, 1'b1)
    `CHK(cfg_rdata, {s3, s2, 3'h0})
    `CHK(mode_rdata, {m3, m2, 3'h0})
    `CHK(en2, s2 < 3'h5)
    `CHK(en3, s3 < 3'h5)
    `CHK(pow2, expv(s2, m2))
    `CHK(pow3, expv(s3, m3))
  endtask : run_case

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    mclk       = 1'b0;
    rstn       = 1'b0;
    cfg_wr     = 1'b0;
    mode_wr    = 1'b0;
    pwr_valid  = 1'b0;
    cfg_wdata  = '0;
    mode_wdata = '0;
    for (int k = 0; k < 5; k++) q[k] = '0;
    do_reset();
    // every code on both outputs, third mask swept up from none
    for (int i = 0; i < 8; i++) run_case(3'(i), 3'(7 - i), 3'h7, 3'(i));
    for (int i = 0; i < 40; i++)
      run_case(3'($random(seed)), 3'($random(seed)),
               3'($random(seed)), 3'($random(seed)));
    // second reset after reserved codes were programmed
    run_case(3'h6, 3'h5, 3'h1, 3'h4);
    // assert reset on a clock edge, not just after the checks
    @(posedge mclk);
    do_reset();
    run_case(3'h4, 3'h3, 3'h5, 3'h2);
    test_done();
  end

  // hang guard, far beyond the under two hundred cycles needed
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule : pss_top_tb

bind pss_top pss_top_assertions #(.PW(PW), .SW(SW)) u_chk (
  .mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
  .mode_rdata(mode_rdata), .pwr_valid(pwr_valid), .sum_valid(sum_valid),
  .second_pulse_output_power(second_pulse_output_power),
  .second_pulse_output_en(second_pulse_output_en),
  .third_pulse_output_power(third_pulse_output_power),
  .third_pulse_output_en(third_pulse_output_en));
